// ### rtl/gaoc_pkg.sv
// Purpose: shared constants and types of the gas alarm and output controller
// Assumes: readings are signed counts where full scale is 1000 counts
// Notes: loop levels are in microamperes, times are converted to cycles or ticks here
package gaoc_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int HOLD_MS = 3000;
   localparam int HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_MS;
   localparam int MENU_TIMEOUT_H = 10;
   localparam int MENU_TIMEOUT_TICKS = MENU_TIMEOUT_H * 3600 * 1000 / TICK_MS;
   localparam int INIT_CLEAR_S = 20;
   localparam int INIT_CLEAR_TICKS = INIT_CLEAR_S * 1000 / TICK_MS;
   localparam int RESULT_MS = 2000;
   localparam int RESULT_TICKS = RESULT_MS / TICK_MS;
   localparam int TICKS_PER_S = 1000 / TICK_MS;
   localparam logic [7:0] ALARM_DELAY_DEFAULT_S = 8'h02;
   localparam int HOLD_CNT_W = 27;
   localparam int LONG_CNT_W = 20;

   localparam logic signed [16:0] FULL_SCALE = 17'sh003E8;
   localparam logic [15:0] SUPPRESS_DEFAULT = 16'h003C;
   localparam logic signed [16:0] NEG_ZERO_LIMIT = 17'sh00064;
   localparam logic [15:0] ZERO_ADJ_LIMIT_DEFAULT = 16'h0064;

   localparam logic [15:0] LOOP_FAULT_UA = 16'h01F4;
   localparam logic [15:0] LOOP_LOW_UA = 16'h09C4;
   localparam logic [15:0] LOOP_ZERO_UA = 16'h0FA0;
   localparam logic [15:0] LOOP_MAX_UA = 16'h55F0;
   localparam logic signed [23:0] LOOP_SLOPE = 24'sh000010;

   typedef enum logic [2:0] {
      MODE_INIT = 3'b000,
      MODE_DETECT = 3'b001,
      MODE_MENU = 3'b010,
      MODE_REGMAINT = 3'b011,
      MODE_FAULT = 3'b100
   } gaoc_mode_e;

   typedef enum logic [1:0] {
      SUB_BROWSE = 2'b00,
      SUB_VIEW = 2'b01,
      SUB_RESULT = 2'b10
   } gaoc_sub_e;

   typedef enum logic [1:0] {
      ITEM_VERSION = 2'b00,
      ITEM_ZERO = 2'b01,
      ITEM_SETTINGS = 2'b10,
      ITEM_REGMAINT = 2'b11
   } gaoc_item_e;

   typedef enum logic [1:0] {
      MOUT_LOW = 2'b00,
      MOUT_ZERO = 2'b01,
      MOUT_HOLD = 2'b10,
      MOUT_LIVE = 2'b11
   } gaoc_mout_e;

   typedef enum logic [3:0] {
      DISP_INIT = 4'h0,
      DISP_CONC = 4'h1,
      DISP_OVER = 4'h2,
      DISP_NEGZERO = 4'h3,
      DISP_ERROR = 4'h4,
      DISP_ITEM = 4'h5,
      DISP_VERSION = 4'h6,
      DISP_SETTINGS = 4'h7,
      DISP_PASS = 4'h8,
      DISP_FAIL = 4'h9
   } gaoc_disp_e;
endpackage : gaoc_pkg

// ### rtl/gaoc_tick_div.sv
// Purpose: divides the system clock down to a one-cycle tick enable
// Assumes: one clock domain, asynchronous active-low reset
// Notes: tick is registered and lasts one cycle every TICK_CYCLES cycles
`timescale 1ns/1ps
`default_nettype none
module gaoc_tick_div #(
   parameter int TICK_CYCLES = 4_000_000
) (
   input wire logic clk,
   input wire logic rst_b,
   output logic tick
);
   localparam int CNT_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

   logic [CNT_W-1:0] cntQ;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cntQ <= '0;
         tick <= 1'b0;
      end else if (cntQ == LAST) begin
         cntQ <= '0;
         tick <= 1'b1;
      end else begin
         cntQ <= cntQ + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule : gaoc_tick_div
`default_nettype wire

// ### rtl/gaoc_top.sv
// Purpose: mode, alarm, display and loop output control of a gas detector head
// Assumes: keys and status inputs are synchronous to clk; reading is raw sensor counts
// Notes: all outputs are registered; loop level is reported in microamperes
// Functional notes
// RQ1: hold menu key three seconds enters menu
// RQ2: ten hours in menu returns to detection
// RQ3: four menu items, confirm activates shown item
// RQ4: failed zero shows fail, keeps old zero
// RQ5: alarm and red lamp at setpoint
// RQ6: alarm delay two seconds default, cancellable
// RQ7: alarm clears itself below setpoint
// RQ8: over range shows over-scale pattern
// RQ9: green power lamp steadily on
// RQ10: fault lights yellow lamp, shows error code
// RQ11: fault clear restarts through initial clear
// RQ12: detection output linear, clamped at 22 mA
// RQ13: init and inhibit drive 2.5 or 4 mA
// RQ14: maintenance output fixed, hold or live
// RQ15: alarm test output live or 4 mA
// RQ16: suppress readings below value in detection
// RQ17: no suppression in maintenance
// RQ18: minus ten percent shows negative zero
// RQ19: fault over inhibit/test/maintenance over detection
`timescale 1ns/1ps
`default_nettype none
module gaoc_top
   import gaoc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int HOLD_CYC = HOLD_CYCLES,
   parameter int MENU_TIMEOUT = MENU_TIMEOUT_TICKS,
   parameter int INIT_TICKS = INIT_CLEAR_TICKS,
   parameter logic [15:0] ZERO_ADJ_LIMIT = ZERO_ADJ_LIMIT_DEFAULT,
   parameter logic [15:0] VERSION_CODE = 16'h0A5C // arbitrary value
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic menu_escape_key,
   input wire logic nextKey,
   input wire logic confirmKey,
   input wire logic signed [15:0] rawReading,
   input wire logic [15:0] alarmSetpoint,
   input wire logic alarmUsed,
   input wire logic [7:0] alarmDelaySec,
   input wire logic alarmDelayCancel,
   input wire logic [15:0] suppressValue,
   input wire logic [1:0] maintOutSel,
   input wire logic inhibitActive,
   input wire logic alarmTestActive,
   input wire logic alarmTestOutOn,
   input wire logic faultDetect,
   input wire logic [7:0] faultCode,
   output logic [2:0] modeOut,
   output logic gasAlarm,
   output logic alarm_lamp,
   output logic powerLamp,
   output logic faultLamp,
   output logic [3:0] dispMode,
   output logic [15:0] dispValue,
   output logic [15:0] loopUa,
   output logic zeroPass
);
   gaoc_mode_e modeQ;
   gaoc_sub_e subQ;
   gaoc_item_e itemQ;
   logic tick;
   logic [HOLD_CNT_W-1:0] holdCntQ;
   logic [LONG_CNT_W-1:0] initCntQ;
   logic [LONG_CNT_W-1:0] maintCntQ;
   logic [LONG_CNT_W-1:0] resCntQ;
   logic [11:0] delayCntQ;
   logic menuPrevQ, nextPrevQ, confPrevQ;
   logic signed [15:0] zeroQ;
   logic signed [16:0] conc;
   logic menuPress, nextPress, confPress;
   logic holdDone, timeoutDone, initDone, zeroOk, alarmCond;
   logic [11:0] delayTicks;
   logic [15:0] suppEff;
   logic [15:0] loopD;
   gaoc_disp_e dispD;
   logic [15:0] dispValD;

   gaoc_tick_div #(.TICK_CYCLES(TICK_CYC)) gaoc_tick_div_i (
      .clk(clk),
      .rst_b(rst_b),
      .tick(tick)
   );

   // signed linear loop current with ceiling and no negative current
   function automatic logic [15:0] linearUa(input logic signed [16:0] c);
      logic signed [23:0] v;
      v = $signed({8'h00, LOOP_ZERO_UA}) + $signed({{7{c[16]}}, c}) * LOOP_SLOPE;
      if (v > $signed({8'h00, LOOP_MAX_UA})) begin
         linearUa = LOOP_MAX_UA;
      end else if (v < 24'sh000000) begin
         linearUa = 16'h0000;
      end else begin
         linearUa = v[15:0];
      end
   endfunction : linearUa

   assign conc = 17'($signed(rawReading)) - 17'($signed(zeroQ));
   assign menuPress = menu_escape_key & ~menuPrevQ;
   assign nextPress = nextKey & ~nextPrevQ;
   assign confPress = confirmKey & ~confPrevQ;
   assign holdDone = (modeQ == MODE_DETECT) && menu_escape_key &&
                     (holdCntQ == HOLD_CNT_W'(HOLD_CYC - 1));
   assign timeoutDone = tick && (maintCntQ == LONG_CNT_W'(MENU_TIMEOUT - 1));
   assign initDone = tick && (initCntQ == LONG_CNT_W'(INIT_TICKS - 1));
   assign zeroOk = (rawReading <= $signed(ZERO_ADJ_LIMIT)) &&
                   (rawReading >= -$signed(ZERO_ADJ_LIMIT));
   assign alarmCond = alarmUsed && (modeQ == MODE_DETECT) &&
                      (conc >= $signed({1'b0, alarmSetpoint}));
   assign delayTicks = (alarmDelaySec == 8'h00) ?
                       12'(ALARM_DELAY_DEFAULT_S * TICKS_PER_S) :
                       12'(alarmDelaySec * TICKS_PER_S);
   assign suppEff = (suppressValue == 16'h0000) ? SUPPRESS_DEFAULT : suppressValue;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         menuPrevQ <= 1'b0;
         nextPrevQ <= 1'b0;
         confPrevQ <= 1'b0;
      end else begin
         menuPrevQ <= menu_escape_key;
         nextPrevQ <= nextKey;
         confPrevQ <= confirmKey;
      end
   end

   // operating mode; a fault overrides every mode
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         modeQ <= MODE_INIT;
      end else if (faultDetect) begin
         modeQ <= MODE_FAULT; // RQ10
      end else begin
         case (modeQ)
            MODE_INIT: if (initDone) modeQ <= MODE_DETECT;
            MODE_DETECT: if (holdDone) modeQ <= MODE_MENU; // RQ1
            MODE_MENU: begin
               if (timeoutDone || (menuPress && subQ == SUB_BROWSE)) begin
                  modeQ <= MODE_DETECT; // RQ2
               end else if (confPress && subQ == SUB_BROWSE && itemQ == ITEM_REGMAINT) begin
                  modeQ <= MODE_REGMAINT; // RQ3
               end
            end
            MODE_REGMAINT: if (timeoutDone || menuPress) modeQ <= MODE_DETECT;
            MODE_FAULT: modeQ <= MODE_INIT; // RQ11
            default: modeQ <= MODE_INIT;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         holdCntQ <= '0;
      end else if (modeQ == MODE_DETECT && menu_escape_key && !holdDone) begin
         holdCntQ <= holdCntQ + 1'b1; // RQ1
      end else begin
         holdCntQ <= '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         initCntQ <= '0;
      end else if (modeQ != MODE_INIT) begin
         initCntQ <= '0;
      end else if (tick) begin
         initCntQ <= initCntQ + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         maintCntQ <= '0;
      end else if (modeQ != MODE_MENU && modeQ != MODE_REGMAINT) begin
         maintCntQ <= '0;
      end else if (tick) begin
         maintCntQ <= maintCntQ + 1'b1; // RQ2
      end
   end

   // user menu browsing and item actions
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         subQ <= SUB_BROWSE;
         itemQ <= ITEM_VERSION;
         resCntQ <= '0;
      end else if (modeQ != MODE_MENU) begin
         subQ <= SUB_BROWSE;
         itemQ <= ITEM_VERSION;
         resCntQ <= '0;
      end else begin
         case (subQ)
            SUB_BROWSE: begin
               resCntQ <= '0;
               if (confPress && (itemQ == ITEM_VERSION || itemQ == ITEM_SETTINGS)) begin
                  subQ <= SUB_VIEW; // RQ3
               end else if (confPress && itemQ == ITEM_ZERO) begin
                  subQ <= SUB_RESULT;
               end else if (nextPress) begin
                  itemQ <= gaoc_item_e'(itemQ + 2'b01);
               end
            end
            SUB_VIEW: if (menuPress || confPress) subQ <= SUB_BROWSE;
            SUB_RESULT: begin
               if (tick && resCntQ == LONG_CNT_W'(RESULT_TICKS - 1)) begin
                  subQ <= SUB_BROWSE; // RQ4
               end else if (tick) begin
                  resCntQ <= resCntQ + 1'b1;
               end
            end
            default: subQ <= SUB_BROWSE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         zeroQ <= 16'sh0000;
         zeroPass <= 1'b0;
      end else if (modeQ == MODE_MENU && subQ == SUB_BROWSE && itemQ == ITEM_ZERO &&
                   confPress) begin
         zeroPass <= zeroOk;
         if (zeroOk) begin
            zeroQ <= rawReading; // RQ4
         end
      end
   end

   // gas alarm with delay; self resetting
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         delayCntQ <= '0;
         gasAlarm <= 1'b0;
         alarm_lamp <= 1'b0;
      end else if (!alarmCond) begin
         delayCntQ <= '0;
         gasAlarm <= 1'b0; // RQ7
         alarm_lamp <= 1'b0;
      end else if (alarmDelayCancel || delayCntQ >= delayTicks) begin
         gasAlarm <= 1'b1; // RQ5
         alarm_lamp <= 1'b1; // RQ6
      end else if (tick) begin
         delayCntQ <= delayCntQ + 1'b1; // RQ6
      end
   end

   // display content
   always_comb begin
      dispD = DISP_CONC;
      dispValD = conc[15:0];
      case (modeQ)
         MODE_INIT: dispD = DISP_INIT;
         MODE_FAULT: begin
            dispD = DISP_ERROR; // RQ10
            dispValD = {8'h00, faultCode};
         end
         MODE_MENU: begin
            case (subQ)
               SUB_VIEW: begin
                  dispD = (itemQ == ITEM_VERSION) ? DISP_VERSION : DISP_SETTINGS;
                  dispValD = (itemQ == ITEM_VERSION) ? VERSION_CODE : alarmSetpoint;
               end
               SUB_RESULT: dispD = zeroPass ? DISP_PASS : DISP_FAIL; // RQ4
               default: begin
                  dispD = DISP_ITEM;
                  dispValD = {14'h0000, itemQ};
               end
            endcase
         end
         MODE_REGMAINT: if (conc > FULL_SCALE) dispD = DISP_OVER; // RQ17
         default: begin
            if (conc > FULL_SCALE) begin
               dispD = DISP_OVER; // RQ8
            end else if (conc <= -NEG_ZERO_LIMIT) begin
               dispD = DISP_NEGZERO; // RQ18
               dispValD = 16'h0000;
            end else if (conc < $signed({1'b0, suppEff})) begin
               dispValD = 16'h0000; // RQ16
            end
         end
      endcase
   end

   // loop level selection by priority
   always_comb begin
      loopD = linearUa(conc); // RQ12
      if (modeQ == MODE_FAULT) begin
         loopD = LOOP_FAULT_UA; // RQ19
      end else if (modeQ == MODE_INIT || inhibitActive) begin
         loopD = (maintOutSel == MOUT_LOW) ? LOOP_LOW_UA : LOOP_ZERO_UA; // RQ13
      end else if (alarmTestActive) begin
         loopD = alarmTestOutOn ? linearUa(conc) : LOOP_ZERO_UA; // RQ15
      end else if (modeQ == MODE_MENU || modeQ == MODE_REGMAINT) begin
         case (gaoc_mout_e'(maintOutSel))
            MOUT_LOW: loopD = LOOP_LOW_UA; // RQ14
            MOUT_ZERO: loopD = LOOP_ZERO_UA;
            MOUT_HOLD: loopD = loopUa;
            default: loopD = linearUa(conc);
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         modeOut <= MODE_INIT;
         powerLamp <= 1'b0;
         faultLamp <= 1'b0;
         dispMode <= DISP_INIT;
         dispValue <= 16'h0000;
         loopUa <= LOOP_LOW_UA;
      end else begin
         modeOut <= modeQ;
         powerLamp <= 1'b1; // RQ9
         faultLamp <= (modeQ == MODE_FAULT); // RQ10
         dispMode <= dispD;
         dispValue <= dispValD;
         loopUa <= loopD;
      end
   end

   sequence faultSeen;
      faultDetect ##1 (modeQ == MODE_FAULT);
   endsequence
   sequence faultGone;
      (modeQ == MODE_FAULT) && !faultDetect ##1 (modeQ == MODE_INIT);
   endsequence

   hold_enter_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
      holdDone && !faultDetect |=> modeQ == MODE_MENU)
      else $error("hold did not enter menu");
   menu_timeout_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
      modeQ == MODE_MENU && timeoutDone && !faultDetect |=> modeQ == MODE_DETECT)
      else $error("menu timeout ignored");
   zero_fail_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ4
      modeQ == MODE_MENU && subQ == SUB_BROWSE && itemQ == ITEM_ZERO && confPress &&
      !zeroOk && !faultDetect |=> $stable(zeroQ) && !zeroPass ##1 dispMode == DISP_FAIL)
      else $error("failed zero not handled");
   alarm_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ5
      alarmCond && alarmDelayCancel |=> gasAlarm && alarm_lamp)
      else $error("alarm not raised");
   alarm_delay_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
      $rose(gasAlarm) |-> $past(alarmDelayCancel) || $past(delayCntQ) >= $past(delayTicks))
      else $error("alarm raised early");
   alarm_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ7
      !alarmCond |=> !gasAlarm && !alarm_lamp)
      else $error("alarm did not clear");
   over_scale_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
      modeQ == MODE_DETECT && conc > FULL_SCALE |=> dispMode == DISP_OVER)
      else $error("over scale not shown");
   power_lamp_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
      $past(rst_b) |-> powerLamp)
      else $error("power lamp off");
   fault_show_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
      faultSeen |=> faultLamp && dispMode == DISP_ERROR && loopUa == LOOP_FAULT_UA)
      else $error("fault not shown");
   fault_restart_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ11
      faultGone |-> initCntQ == '0)
      else $error("no initial clear after fault");
   loop_clamp_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ12
      loopUa <= LOOP_MAX_UA)
      else $error("loop above ceiling");
   init_out_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ13
      modeQ == MODE_INIT && maintOutSel == MOUT_HOLD |=> loopUa == LOOP_ZERO_UA)
      else $error("init loop level wrong");
   maint_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ14
      modeQ == MODE_REGMAINT && !inhibitActive && !alarmTestActive &&
      maintOutSel == MOUT_HOLD |=> $stable(loopUa))
      else $error("hold level moved");
   test_out_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ15
      modeQ == MODE_DETECT && !inhibitActive && alarmTestActive && !alarmTestOutOn
      |=> loopUa == LOOP_ZERO_UA)
      else $error("alarm test level wrong");
   suppress_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ16
      modeQ == MODE_DETECT && conc > -NEG_ZERO_LIMIT && conc < $signed({1'b0, suppEff})
      |=> dispValue == 16'h0000 && dispMode == DISP_CONC)
      else $error("suppression missing");
   no_suppress_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ17
      modeQ == MODE_REGMAINT && conc <= FULL_SCALE |=> dispValue == 16'($past(conc)))
      else $error("maintenance reading altered");
   neg_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ18
      modeQ == MODE_DETECT && conc <= -NEG_ZERO_LIMIT |=> dispMode == DISP_NEGZERO)
      else $error("negative zero not shown");
endmodule : gaoc_top
`default_nettype wire

// ### tb/gaoc_loop_reader.sv
// Purpose: far-side model of the central system that reads the loop current
// Assumes: loop level arrives in microamperes, one reading per clk
// Notes: latches a flag if the level ever goes above the 22 mA clamp
`timescale 1ns/1ps
`default_nettype none
module gaoc_loop_reader
   import gaoc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] loopUa,
   output logic [15:0] lastUa,
   output logic overRange
);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lastUa <= 16'h0000;
      end else begin
         lastUa <= loopUa;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         overRange <= 1'b0;
      end else if (loopUa > LOOP_MAX_UA) begin
         overRange <= 1'b1;
      end
   end
endmodule : gaoc_loop_reader
`default_nettype wire

// ### tb/gaoc_top_tb_top.sv
// Purpose: self-checking bench of the gas alarm and output controller
// Assumes: shortened tick, hold, menu and init counts
// Notes: inputs change at the falling edge; one line per finished test
`timescale 1ns/1ps
`default_nettype none
module gaoc_top_tb_top
   import gaoc_pkg::*;
;
   localparam int TCK = 10;
   localparam int HOLDC = 20;
   localparam int MTO = 60;
   localparam int INITT = 3;
   logic clk = 1'b0, rst_b = 1'b0, escKey = 1'b0, nextKey = 1'b0, confirmKey = 1'b0;
   logic signed [15:0] rawReading = 16'h0000;
   logic [15:0] alarmSetpoint = 16'h012C, suppressValue = 16'h0000;
   logic alarmUsed = 1'b0, alarmDelayCancel = 1'b0, inhibitActive = 1'b0;
   logic alarmTestActive = 1'b0, alarmTestOutOn = 1'b0, faultDetect = 1'b0;
   logic [7:0] alarmDelaySec = 8'h01, faultCode = 8'h5A;
   logic [1:0] maintOutSel = 2'b00;
   logic [2:0] modeOut;
   logic gasAlarm, alarmLamp, powerLamp, faultLamp, zeroPass, overRange;
   logic [3:0] dispMode;
   logic [15:0] dispValue, loopUa, lastUa;
   int error_cnt = 0, checks = 0, cycles = 0;

   gaoc_top #(.TICK_CYC(TCK), .HOLD_CYC(HOLDC), .MENU_TIMEOUT(MTO), .INIT_TICKS(INITT)) gaoc_top_i (
      .clk(clk), .rst_b(rst_b), .menu_escape_key(escKey), .nextKey(nextKey),
      .confirmKey(confirmKey), .rawReading(rawReading), .alarmSetpoint(alarmSetpoint),
      .alarmUsed(alarmUsed), .alarmDelaySec(alarmDelaySec), .alarmDelayCancel(alarmDelayCancel),
      .suppressValue(suppressValue), .maintOutSel(maintOutSel), .inhibitActive(inhibitActive),
      .alarmTestActive(alarmTestActive), .alarmTestOutOn(alarmTestOutOn),
      .faultDetect(faultDetect), .faultCode(faultCode), .modeOut(modeOut), .gasAlarm(gasAlarm),
      .alarm_lamp(alarmLamp), .powerLamp(powerLamp), .faultLamp(faultLamp),
      .dispMode(dispMode), .dispValue(dispValue), .loopUa(loopUa), .zeroPass(zeroPass));

   gaoc_loop_reader gaoc_loop_reader_i (.clk(clk), .rst_b(rst_b), .loopUa(loopUa),
      .lastUa(lastUa), .overRange(overRange));

   always #12.5 clk = ~clk;

   task automatic test_done();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // hang guard: the sequence needs a few thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [15:0] pick(input int sel);
      case (sel)
         0: return 16'(modeOut);
         1: return 16'(dispMode);
         default: return 16'(gasAlarm);
      endcase
   endfunction : pick

   task automatic waitOn(input int sel, input logic [15:0] exp, input int lim);
      int n;
      n = 0;
      while (pick(sel) !== exp && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(sel == 0 ? "mode" : sel == 1 ? "disp" : "alarm", exp, pick(sel));
   endtask : waitOn

   function automatic logic [15:0] ua(input int v);
      return 16'(int'(LOOP_ZERO_UA) + 16 * v);
   endfunction : ua

   task automatic settle();
      repeat (4) @(negedge clk);
   endtask : settle

   task automatic setRaw(input int v);
      @(negedge clk);
      rawReading = 16'(v);
      settle();
   endtask : setRaw

   // k: 0 menu/escape, 1 next, 2 confirm; one-cycle press
   task automatic press(input int k);
      @(negedge clk);
      case (k)
         0: escKey = 1'b1;
         1: nextKey = 1'b1;
         default: confirmKey = 1'b1;
      endcase
      @(negedge clk);
      escKey = 1'b0;
      nextKey = 1'b0;
      confirmKey = 1'b0;
      settle();
   endtask : press

   task automatic holdEsc();
      @(negedge clk);
      escKey = 1'b1;
      repeat (HOLDC - 4) @(negedge clk);
      chk("mode", 16'(MODE_DETECT), 16'(modeOut));
      repeat (8) @(negedge clk);
      escKey = 1'b0;
      waitOn(0, 16'(MODE_MENU), 10);
   endtask : holdEsc

   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      chk("power", 16'h0001, 16'(powerLamp));
      chk("loop", LOOP_LOW_UA, loopUa);
      waitOn(0, 16'(MODE_DETECT), INITT * TCK + 50);
      $display("test init done");
      setRaw(50);
      chk("dmode", 16'(DISP_CONC), 16'(dispMode));
      chk("dval", 16'h0000, dispValue);
      chk("loop", ua(50), loopUa);
      setRaw(60);
      chk("dval", 16'h003C, dispValue);
      suppressValue = 16'h0050;
      settle();
      chk("dval", 16'h0000, dispValue);
      suppressValue = 16'h0000;
      setRaw(-99);
      chk("dval", 16'h0000, dispValue);
      setRaw(-100);
      chk("dmode", 16'(DISP_NEGZERO), 16'(dispMode));
      setRaw(1200);
      chk("dmode", 16'(DISP_OVER), 16'(dispMode));
      chk("loop", LOOP_MAX_UA, loopUa);
      setRaw(1120);
      chk("loop", ua(1120), loopUa);
      $display("test display done");
      alarmUsed = 1'b1;
      setRaw(299);
      chk("alarm", 16'h0000, 16'(gasAlarm));
      setRaw(300);
      repeat (70) @(negedge clk);
      chk("alarm", 16'h0000, 16'(gasAlarm));
      waitOn(2, 16'h0001, 60);
      chk("lamp", 16'h0001, 16'(alarmLamp));
      setRaw(299);
      chk("alarm", 16'h0000, 16'(gasAlarm));
      chk("lamp", 16'h0000, 16'(alarmLamp));
      alarmDelayCancel = 1'b1;
      setRaw(300);
      chk("alarm", 16'h0001, 16'(gasAlarm));
      alarmDelayCancel = 1'b0;
      alarmDelaySec = 8'h00;
      setRaw(299);
      setRaw(300);
      repeat (150) @(negedge clk);
      chk("alarm", 16'h0000, 16'(gasAlarm));
      waitOn(2, 16'h0001, 80);
      alarmUsed = 1'b0;
      setRaw(500);
      $display("test alarm done");
      alarmTestActive = 1'b1;
      alarmTestOutOn = 1'b1;
      inhibitActive = 1'b1;
      settle();
      chk("loop", LOOP_LOW_UA, loopUa);
      maintOutSel = 2'b01;
      settle();
      chk("loop", LOOP_ZERO_UA, loopUa);
      inhibitActive = 1'b0;
      settle();
      chk("loop", ua(500), loopUa);
      chk("reader", ua(500), lastUa);
      alarmTestOutOn = 1'b0;
      settle();
      chk("loop", LOOP_ZERO_UA, loopUa);
      alarmTestActive = 1'b0;
      $display("test loop modes done");
      holdEsc();
      chk("dmode", 16'(DISP_ITEM), 16'(dispMode));
      chk("dval", 16'h0000, dispValue);
      press(2);
      chk("dmode", 16'(DISP_VERSION), 16'(dispMode));
      press(0);
      chk("dmode", 16'(DISP_ITEM), 16'(dispMode));
      press(1);
      press(1);
      chk("dval", 16'h0002, dispValue);
      press(2);
      chk("dmode", 16'(DISP_SETTINGS), 16'(dispMode));
      chk("dval", 16'h012C, dispValue);
      press(2);
      press(1);
      press(2);
      waitOn(0, 16'(MODE_REGMAINT), 10);
      maintOutSel = 2'b11;
      setRaw(50);
      chk("dval", 16'h0032, dispValue);
      chk("loop", ua(50), loopUa);
      maintOutSel = 2'b10;
      setRaw(100);
      chk("loop", ua(50), loopUa);
      maintOutSel = 2'b00;
      settle();
      chk("loop", LOOP_LOW_UA, loopUa);
      maintOutSel = 2'b01;
      settle();
      chk("loop", LOOP_ZERO_UA, loopUa);
      waitOn(0, 16'(MODE_DETECT), MTO * TCK + 50);
      $display("test menu done");
      holdEsc();
      press(1);
      setRaw(500);
      press(2);
      chk("dmode", 16'(DISP_FAIL), 16'(dispMode));
      chk("zpass", 16'h0000, 16'(zeroPass));
      waitOn(1, 16'(DISP_ITEM), RESULT_TICKS * TCK + 50);
      chk("dval", 16'h0001, dispValue);
      setRaw(20);
      press(2);
      chk("dmode", 16'(DISP_PASS), 16'(dispMode));
      chk("zpass", 16'h0001, 16'(zeroPass));
      waitOn(1, 16'(DISP_ITEM), RESULT_TICKS * TCK + 50);
      press(0);
      waitOn(0, 16'(MODE_DETECT), 10);
      setRaw(80);
      chk("dval", 16'h003C, dispValue);
      holdEsc();
      waitOn(0, 16'(MODE_DETECT), MTO * TCK + 50);
      $display("test zero done");
      maintOutSel = 2'b10;
      inhibitActive = 1'b1;
      faultDetect = 1'b1;
      settle();
      chk("flamp", 16'h0001, 16'(faultLamp));
      chk("dmode", 16'(DISP_ERROR), 16'(dispMode));
      chk("dval", 16'h005A, dispValue);
      chk("loop", LOOP_FAULT_UA, loopUa);
      faultDetect = 1'b0;
      inhibitActive = 1'b0;
      waitOn(0, 16'(MODE_INIT), 10);
      @(negedge clk);
      chk("loop", LOOP_ZERO_UA, loopUa);
      waitOn(0, 16'(MODE_DETECT), INITT * TCK + 50);
      chk("over", 16'h0000, 16'(overRange));
      $display("test fault done");
      test_done();
   end
endmodule : gaoc_top_tb_top
`default_nettype wire
